// [design/port_alt_override.v]
/*
  Port pin alternate function override logic for port E, port F and the
  port G reset pin, with a small scan port controller on port F bits 7:4.
  Assumes pads that take registered value, active-low output enable and
  pull-up enable; peripheral enables arrive on ref_clk; fuses are static.
*/
// Our own choices: the APB slave port and the placing of the registers.
// Function
// - Clock pin direction follows its direction bit
// - Sync clock override only in synchronous mode
// - Receiver enable forces bit 0 input
// - Forced receive input pulls up on latch one
// - Change mask and group enable enable input
// - Two-wire mode: no pull-ups, drive low only
// - Transmitter: no pull-up, output, transmit data
// - Clock fuse drives divided clock on bit 7
// - Scan enabled keeps scan input pull-ups on
// - Scan enabled hides port F 7:4
// - Shift data-in into selected scan chain
// - Data-out driven only in shift states
// - Mode select steers the tap controller
// - Scan logic follows the test clock
// - Scan pins: pull-up, no input, only data-out driven, the other three held as inputs
// - Port F 3:0 have no overrides
// - Reset pin input only, pull-up always
`include "port_alt_override_defines.vh"
`default_nettype none

module port_alt_override #(
  parameter CLKOUT_DIV = `PAO_CLKOUT_DIV
) (
  input  wire        ref_clk,
  input  wire        srst,
  input  wire [7:0]  paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         irq,
  input  wire [7:0]  portEIn,
  output reg  [7:0]  portEOut,
  output reg  [7:0]  portEOeN,
  output reg  [7:0]  portEPullup,
  output reg  [7:0]  portEDigIn,
  input  wire [7:0]  portFIn,
  output reg  [7:0]  portFOut,
  output reg  [7:0]  portFOeN,
  output reg  [7:0]  portFPullup,
  input  wire        resetInputPin,
  output reg         resetPinPullup,
  input  wire        receiverEnable,
  input  wire        transmitterEnable,
  input  wire        txData,
  input  wire        usartSyncMode,
  input  wire        usartSyncClock,
  input  wire        serialIfaceTwoWireMode,
  input  wire        serialIfaceThreeWireMode,
  input  wire        serialDataOut,
  input  wire        serialDataHold,
  input  wire        serialClockHold,
  input  wire        clockOutputFuse,
  input  wire        scanPortEnable
);

  // ============================================================
  // Register file
  reg [7:0]  portELatch_r;
  reg [7:0]  portEDir_r;
  reg [7:0]  portFLatch_r;
  reg [7:0]  portFDir_r;
  reg [7:0]  changeMask_r;
  reg [3:0]  ctrl_r;
  reg [8:0]  status_r;
  reg [8:0]  irqMask_r;
  reg [7:0]  scanData_r;

  wire groupEnable        = ctrl_r[`PAO_CTRL_GROUP_EN];
  wire globalPullupDisable = ctrl_r[`PAO_CTRL_PULLUP_DIS];

  // ============================================================
  // Pin synchronisers
  reg [7:0] peSync1_r;
  reg [7:0] peSync2_r;
  reg [7:0] pePrev_r;
  reg [7:0] pfSync1_r;
  reg [7:0] pfSync2_r;
  reg       rstSync1_r;
  reg       rstSync2_r;
  reg       tckPrev_r;

  always @(posedge ref_clk) begin
    peSync1_r  <= portEIn;
    peSync2_r  <= peSync1_r;
    pePrev_r   <= peSync2_r;
    pfSync1_r  <= portFIn;
    pfSync2_r  <= pfSync1_r;
    rstSync1_r <= resetInputPin;
    rstSync2_r <= rstSync1_r;
    tckPrev_r  <= pfSync2_r[4];
  end

  // Data-in, mode select and test clock share one sync depth so they stay aligned
  wire tckRise = pfSync2_r[4] & ~tckPrev_r;
  wire tckFall = ~pfSync2_r[4] & tckPrev_r;
  wire tmsIn   = pfSync2_r[5];
  wire tdiIn   = pfSync2_r[7];

  // ============================================================
  // Divided clock for the clock output pin
  reg [7:0] divCnt_r;
  reg       clkOutLevel_r;

  always @(posedge ref_clk) begin
    if (srst) begin
      divCnt_r      <= 8'h00;
      clkOutLevel_r <= 1'b0;
    end else if (divCnt_r == CLKOUT_DIV[7:0] - 8'h01) begin
      divCnt_r      <= 8'h00;
      clkOutLevel_r <= ~clkOutLevel_r;
    end else begin
      divCnt_r      <= divCnt_r + 8'h01;
    end
  end

  // ============================================================
  // Tap controller, advanced on sampled test clock edges
  localparam [3:0] ST_RESET     = 4'h0;
  localparam [3:0] ST_IDLE      = 4'h1;
  localparam [3:0] ST_SEL_DR    = 4'h2;
  localparam [3:0] ST_CAP_DR    = 4'h3;
  localparam [3:0] ST_SHIFT_DR  = 4'h4;
  localparam [3:0] ST_EXIT1_DR  = 4'h5;
  localparam [3:0] ST_PAUSE_DR  = 4'h6;
  localparam [3:0] ST_EXIT2_DR  = 4'h7;
  localparam [3:0] ST_UPD_DR    = 4'h8;
  localparam [3:0] ST_SEL_IR    = 4'h9;
  localparam [3:0] ST_CAP_IR    = 4'hA;
  localparam [3:0] ST_SHIFT_IR  = 4'hB;
  localparam [3:0] ST_EXIT1_IR  = 4'hC;
  localparam [3:0] ST_PAUSE_IR  = 4'hD;
  localparam [3:0] ST_EXIT2_IR  = 4'hE;
  localparam [3:0] ST_UPD_IR    = 4'hF;

  reg [3:0] tapState_r;
  reg [3:0] tapState_nxt;
  reg [3:0] irShift_r;
  reg [3:0] ir_r;
  reg [7:0] drShift_r;
  reg       bypass_r;
  reg       tdo_r;

  always @* begin
    case (tapState_r)
      ST_RESET:    tapState_nxt = tmsIn ? ST_RESET   : ST_IDLE;
      ST_IDLE:     tapState_nxt = tmsIn ? ST_SEL_DR  : ST_IDLE;
      ST_SEL_DR:   tapState_nxt = tmsIn ? ST_SEL_IR  : ST_CAP_DR;
      ST_CAP_DR:   tapState_nxt = tmsIn ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: tapState_nxt = tmsIn ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: tapState_nxt = tmsIn ? ST_UPD_DR  : ST_PAUSE_DR;
      ST_PAUSE_DR: tapState_nxt = tmsIn ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: tapState_nxt = tmsIn ? ST_UPD_DR  : ST_SHIFT_DR;
      ST_UPD_DR:   tapState_nxt = tmsIn ? ST_SEL_DR  : ST_IDLE;
      ST_SEL_IR:   tapState_nxt = tmsIn ? ST_RESET   : ST_CAP_IR;
      ST_CAP_IR:   tapState_nxt = tmsIn ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: tapState_nxt = tmsIn ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: tapState_nxt = tmsIn ? ST_UPD_IR  : ST_PAUSE_IR;
      ST_PAUSE_IR: tapState_nxt = tmsIn ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: tapState_nxt = tmsIn ? ST_UPD_IR  : ST_SHIFT_IR;
      ST_UPD_IR:   tapState_nxt = tmsIn ? ST_SEL_DR  : ST_IDLE;
      default:     tapState_nxt = ST_RESET;
    endcase
  end

  wire shiftIr    = (tapState_r == ST_SHIFT_IR);
  wire shiftDr    = (tapState_r == ST_SHIFT_DR);
  wire userDrSel  = (ir_r == `PAO_IR_USER_DATA);
  wire scanUpdate = scanPortEnable & tckRise & (tapState_r == ST_UPD_DR) & userDrSel;

  // Scan state only moves on test clock edges; ref_clk merely samples them
  always @(posedge ref_clk) begin
    if (srst || !scanPortEnable) begin
      tapState_r <= ST_RESET;
      irShift_r  <= `PAO_RST_IR;
      ir_r       <= `PAO_RST_IR;
      drShift_r  <= `PAO_RST_BYTE;
      bypass_r   <= 1'b0;
      scanData_r <= `PAO_RST_BYTE;
      tdo_r      <= 1'b1;
    end else begin
      if (tckRise) begin
        tapState_r <= tapState_nxt;
        case (tapState_r)
          ST_RESET:    ir_r      <= `PAO_RST_IR;
          ST_CAP_IR:   irShift_r <= `PAO_IR_CAPTURE;
          ST_SHIFT_IR: irShift_r <= {tdiIn, irShift_r[3:1]};
          ST_UPD_IR:   ir_r      <= irShift_r;
          ST_CAP_DR: begin
            drShift_r <= scanData_r;
            bypass_r  <= 1'b0;
          end
          ST_SHIFT_DR: begin
            if (userDrSel) begin
              drShift_r <= {tdiIn, drShift_r[7:1]};
            end else begin
              bypass_r  <= tdiIn;
            end
          end
          ST_UPD_DR: begin
            if (userDrSel) begin
              scanData_r <= drShift_r;
            end
          end
          default: begin
          end
        endcase
      end
      // Data-out changes on the falling edge so the tester samples a stable bit
      if (tckFall) begin
        tdo_r <= shiftIr ? irShift_r[0] : (userDrSel ? drShift_r[0] : bypass_r);
      end
    end
  end

  // ============================================================
  // Port E overrides
  reg [7:0] peDir;
  reg [7:0] peVal;
  reg [7:0] pePull;
  reg [7:0] peDie;
  reg       syncClkOutEn;

  always @* begin
    peDir  = portEDir_r;
    peVal  = portELatch_r;
    pePull = portELatch_r & ~portEDir_r & {8{~globalPullupDisable}};
    peDie  = changeMask_r & {8{groupEnable}};
    syncClkOutEn = usartSyncMode & portEDir_r[2];
    // Bit 7: clock output
    if (clockOutputFuse) begin
      peDir[7] = 1'b1;
      peVal[7] = clkOutLevel_r;
    end
    // Bit 6: three-wire data out
    if (serialIfaceThreeWireMode) begin
      peVal[6] = serialDataOut;
    end
    // Bits 5:4: two-wire open-drain behaviour
    if (serialIfaceTwoWireMode) begin
      pePull[5] = 1'b0;
      pePull[4] = 1'b0;
      peDir[5]  = (serialDataHold | portELatch_r[5]) & portEDir_r[5];
      peDir[4]  = (serialClockHold | portELatch_r[4]) & portEDir_r[4];
      if (portEDir_r[5]) begin
        peVal[5] = 1'b0;
      end
      if (portEDir_r[4]) begin
        peVal[4] = 1'b0;
      end
    end
    // Bits 3:2: comparator inputs may drop the digital path
    peDie[3] = peDie[3] & ~ctrl_r[`PAO_CTRL_AIN1_DIS];
    peDie[2] = peDie[2] & ~ctrl_r[`PAO_CTRL_AIN0_DIS];
    if (usartSyncMode) begin
      peDir[2] = portEDir_r[2];
      if (syncClkOutEn) begin
        peVal[2]  = usartSyncClock;
        pePull[2] = 1'b0;
      end
    end
    // Bit 1: transmitter
    if (transmitterEnable) begin
      pePull[1] = 1'b0;
      peDir[1]  = 1'b1;
      peVal[1]  = txData;
    end
    // Bit 0: receiver
    if (receiverEnable) begin
      peDir[0]  = 1'b0;
      pePull[0] = portELatch_r[0] & ~globalPullupDisable;
    end
  end

  // ============================================================
  // Port F overrides
  reg [7:0] pfDir;
  reg [7:0] pfVal;
  reg [7:0] pfPull;
  reg [7:0] pfDie;

  always @* begin
    // Bits 3:0 keep plain port behaviour at all times
    pfDir  = portFDir_r;
    pfVal  = portFLatch_r;
    pfPull = portFLatch_r & ~portFDir_r & {8{~globalPullupDisable}};
    pfDie  = 8'hFF;
    if (scanPortEnable) begin
      pfPull[7:4] = 4'hF;
      pfDie[7:4]  = 4'h0;
      pfDir[7]    = 1'b0;
      pfDir[5:4]  = 2'b00;
      pfDir[6]    = shiftIr | shiftDr;
      pfVal[7:4]  = {1'b0, tdo_r, 2'b00};
      // Undriven data-out still floats high through its pull-up
    end
  end

  // ============================================================
  // Pad registers; they load during reset too so scan pull-ups never drop
  always @(posedge ref_clk) begin
    portEOut       <= peVal;
    portEOeN       <= ~peDir;
    portEPullup    <= pePull;
    portEDigIn     <= peSync2_r & peDie;
    portFOut       <= pfVal;
    portFOeN       <= ~pfDir;
    portFPullup    <= pfPull;
    resetPinPullup <= 1'b1;
  end

  // ============================================================
  // Status and interrupt
  wire [7:0] changeEvt = (peSync2_r ^ pePrev_r) & changeMask_r & {8{groupEnable}};
  wire       apbAccess = psel & penable & pready;
  wire       apbWrite  = apbAccess & pwrite;
  wire [8:0] statusClr = (apbWrite && paddr == `PAO_OFS_IRQ_STATUS) ? pwdata[8:0] : 9'h000;
  wire [8:0] statusSet = {scanUpdate, changeEvt};

  always @(posedge ref_clk) begin
    if (srst) begin
      status_r <= `PAO_RST_STATUS;
      irq      <= 1'b0;
    end else begin
      // A new event in the clearing cycle survives the clear
      status_r <= (status_r & ~statusClr) | statusSet;
      irq      <= |(status_r & irqMask_r);
    end
  end

  // ============================================================
  // APB slave: one wait state, answer in the second access cycle
  reg        mapped;
  reg [31:0] rdMux;

  always @* begin
    mapped = 1'b1;
    rdMux  = 32'h0000_0000;
    case (paddr)
      `PAO_OFS_PORTE_LATCH: rdMux[7:0] = portELatch_r;
      `PAO_OFS_PORTE_DIR:   rdMux[7:0] = portEDir_r;
      `PAO_OFS_PORTE_PIN:   rdMux[7:0] = peSync2_r;
      `PAO_OFS_PORTF_LATCH: rdMux[7:0] = portFLatch_r;
      `PAO_OFS_PORTF_DIR:   rdMux[7:0] = portFDir_r;
      `PAO_OFS_PORTF_PIN:   rdMux[7:0] = pfSync2_r & pfDie;
      `PAO_OFS_CHANGE_MASK: rdMux[7:0] = changeMask_r;
      `PAO_OFS_CTRL:        rdMux[3:0] = ctrl_r;
      `PAO_OFS_IRQ_STATUS:  rdMux[8:0] = status_r;
      `PAO_OFS_IRQ_MASK:    rdMux[8:0] = irqMask_r;
      `PAO_OFS_SCAN_DATA:   rdMux[7:0] = scanData_r;
      `PAO_OFS_MISC_STATUS: rdMux[5:0] = {tapState_r, scanPortEnable, rstSync2_r};
      default:              mapped     = 1'b0;
    endcase
  end

  always @(posedge ref_clk) begin
    if (srst) begin
      pready       <= 1'b0;
      pslverr      <= 1'b0;
      prdata       <= 32'h0000_0000;
      portELatch_r <= `PAO_RST_BYTE;
      portEDir_r   <= `PAO_RST_BYTE;
      portFLatch_r <= `PAO_RST_BYTE;
      portFDir_r   <= `PAO_RST_BYTE;
      changeMask_r <= `PAO_RST_BYTE;
      ctrl_r       <= `PAO_RST_CTRL;
      irqMask_r    <= `PAO_RST_STATUS;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      if (psel && penable && !pready) begin
        prdata <= pwrite ? 32'h0000_0000 : rdMux;
      end
      if (apbWrite && !pslverr) begin
        case (paddr)
          `PAO_OFS_PORTE_LATCH: portELatch_r <= pwdata[7:0];
          `PAO_OFS_PORTE_DIR:   portEDir_r   <= pwdata[7:0];
          `PAO_OFS_PORTF_LATCH: portFLatch_r <= pwdata[7:0];
          `PAO_OFS_PORTF_DIR:   portFDir_r   <= pwdata[7:0];
          `PAO_OFS_CHANGE_MASK: changeMask_r <= pwdata[7:0];
          `PAO_OFS_CTRL:        ctrl_r       <= pwdata[3:0];
          `PAO_OFS_IRQ_MASK:    irqMask_r    <= pwdata[8:0];
          default: begin
          end
        endcase
      end
    end
  end

endmodule // port_alt_override

`default_nettype wire

// [design/port_alt_override_defines.vh]
/*
  Register offsets, reset values and timing constants for the port alternate
  function override block. Assumes a 32-bit APB with byte addresses.
*/
`ifndef PORT_ALT_OVERRIDE_DEFINES_VH
`define PORT_ALT_OVERRIDE_DEFINES_VH

// ============================================================
// Register byte offsets
`define PAO_OFS_PORTE_LATCH   8'h00
`define PAO_OFS_PORTE_DIR     8'h04
`define PAO_OFS_PORTE_PIN     8'h08
`define PAO_OFS_PORTF_LATCH   8'h0C
`define PAO_OFS_PORTF_DIR     8'h10
`define PAO_OFS_PORTF_PIN     8'h14
`define PAO_OFS_CHANGE_MASK   8'h18
`define PAO_OFS_CTRL          8'h1C
`define PAO_OFS_IRQ_STATUS    8'h20
`define PAO_OFS_IRQ_MASK      8'h24
`define PAO_OFS_SCAN_DATA     8'h28
`define PAO_OFS_MISC_STATUS   8'h2C

// ============================================================
// Control register fields
`define PAO_CTRL_GROUP_EN     0
`define PAO_CTRL_PULLUP_DIS   1
`define PAO_CTRL_AIN0_DIS     2
`define PAO_CTRL_AIN1_DIS     3

// ============================================================
// Status fields
`define PAO_ST_SCAN_UPDATE    8
`define PAO_ST_WIDTH          9

// ============================================================
// Reset values and instruction codes
`define PAO_RST_BYTE          8'h00
`define PAO_RST_CTRL          4'h0
`define PAO_RST_STATUS        9'h000
`define PAO_RST_IR            4'hF
`define PAO_IR_CAPTURE        4'h1
`define PAO_IR_BYPASS         4'hF
`define PAO_IR_USER_DATA      4'h2

// ============================================================
// Timing
`define PAO_CLKOUT_DIV        8

`endif

// [tb/pad_bank.sv]
/* Board-side model of one 8-bit port: resolves each pad level.
   Assumes active-low output enable and active-high pull-up enable. */
`default_nettype none
module pad_bank (
  input  wire logic       ref_clk,
  input  wire logic [7:0] oeN,
  input  wire logic [7:0] out,
  input  wire logic [7:0] pullEn,
  input  wire logic [7:0] extEn,
  input  wire logic [7:0] extVal,
  output var  logic [7:0] pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // Pad resolution
  // A floating pad flips every cycle so no stale level can pass a check
  logic [7:0] float_r = 8'h00;
  always @(posedge ref_clk) float_r <= ~float_r;
  always_comb
    for (int i = 0; i < 8; i++)
      pin[i] = !oeN[i] ? out[i] : extEn[i] ? extVal[i] : pullEn[i] ? 1'b1 : float_r[i];
endmodule // pad_bank
`default_nettype wire

// [tb/port_alt_override_props.sv]
/* Checker for the port override block: pad overrides and APB timing.
   Assumes one clock, ref_clk, and synchronous srst; bound to the top. */
`default_nettype none
module port_alt_override_props #(
  parameter int CLKOUT_DIV = 8
) (
  input wire logic       ref_clk,
  input wire logic       srst,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic [7:0] portEOut,
  input wire logic [7:0] portEOeN,
  input wire logic [7:0] portEPullup,
  input wire logic [7:0] portFOeN,
  input wire logic [7:0] portFPullup,
  input wire logic       resetPinPullup,
  input wire logic       receiverEnable,
  input wire logic       transmitterEnable,
  input wire logic       txData,
  input wire logic       serialIfaceTwoWireMode,
  input wire logic       clockOutputFuse,
  input wire logic       scanPortEnable
);
  timeunit 1ns;
  timeprecision 1ps;
  // Generous: the divider may sit anywhere in its count when the fuse rises
  localparam int CW = 2 * CLKOUT_DIV + 2;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  // ==========
  // Pad overrides and APB answer timing
  a_rx_input: assert property (receiverEnable |=> portEOeN[0])
    else $error("receive pin not an input");
  a_tx_drive: assert property (transmitterEnable |=>
    !portEOeN[1] && !portEPullup[1] && portEOut[1] == $past(txData))
    else $error("transmit pin not driven with data");
  a_two_wire: assert property (serialIfaceTwoWireMode |=> portEPullup[5:4] == 2'h0
    && (portEOut[5:4] & ~portEOeN[5:4]) == 2'h0)
    else $error("two-wire pin pulls up or drives high");
  a_clk_pin: assert property (clockOutputFuse |=> !portEOeN[7])
    else $error("clock pin not driven");
  a_clk_toggle: assert property (clockOutputFuse[*2] |-> ##[1:CW]
    (!clockOutputFuse || portEOut[7] != $past(portEOut[7])))
    else $error("clock pin stuck");
  a_scan_pullups: assert property (scanPortEnable |=> portFPullup[7:4] == 4'hF)
    else $error("scan pull-ups off");
  a_scan_inputs: assert property (scanPortEnable |=>
    portFOeN[7] && portFOeN[5] && portFOeN[4])
    else $error("scan input pin driven");
  a_reset_pullup: assert property (1'b1 |=> resetPinPullup)
    else $error("reset pin pull-up off");
  a_apb_answer: assert property (psel && !penable ##1 psel && penable |=> pready ##1 !pready)
    else $error("ready not in second access cycle");
endmodule // port_alt_override_props

bind port_alt_override port_alt_override_props #(.CLKOUT_DIV(CLKOUT_DIV)) i_props (
  .ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable), .pready(pready),
  .portEOut(portEOut), .portEOeN(portEOeN), .portEPullup(portEPullup),
  .portFOeN(portFOeN), .portFPullup(portFPullup), .resetPinPullup(resetPinPullup),
  .receiverEnable(receiverEnable), .transmitterEnable(transmitterEnable),
  .txData(txData), .serialIfaceTwoWireMode(serialIfaceTwoWireMode),
  .clockOutputFuse(clockOutputFuse), .scanPortEnable(scanPortEnable));
`default_nettype wire

// [tb/testbench.sv]
/* Bench for the port override block: APB master, pad models on ports
   E and F, scan tester on port F 7:4. Assumes the block's defines header. */
`include "port_alt_override_defines.vh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DIV = 2;
  logic        ref_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = '0, eIn, eOut, eOeN, ePull, eDig, fIn, fOut, fOeN, fPull;
  logic [31:0] pwdata = '0, prdata, q;
  logic        pready, pslverr, irq, rstPull, e;
  logic [7:0]  eExt = '0, fExt = '0, fExtEn = '0, lat, dir, m;
  logic        receiver_enable = 0, transmitter_enable = 0, txd = 0, syncMode = 0, syncClk = 0;
  logic        twoWire = 0, fuse = 0, scanEn = 0, rstPin = 1;
  logic        threeWire = 0, dataHold = 0, clkHold = 0;
  logic [16:0] lfsr = 17'h11505;
  int          n_errors = 0, checks = 0, cycles = 0, n;

  port_alt_override #(.CLKOUT_DIV(DIV)) i_dut (
    .ref_clk(ref_clk), .srst(srst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .portEIn(eIn), .portEOut(eOut), .portEOeN(eOeN), .portEPullup(ePull),
    .portEDigIn(eDig), .portFIn(fIn), .portFOut(fOut), .portFOeN(fOeN), .portFPullup(fPull),
    .resetInputPin(rstPin), .resetPinPullup(rstPull), .receiverEnable(receiver_enable),
    .transmitterEnable(transmitter_enable), .txData(txd), .usartSyncMode(syncMode), .usartSyncClock(syncClk),
    .serialIfaceTwoWireMode(twoWire), .serialIfaceThreeWireMode(threeWire), .serialDataOut(txd),
    .serialDataHold(dataHold), .serialClockHold(clkHold), .clockOutputFuse(fuse), .scanPortEnable(scanEn));
  pad_bank i_padE (.ref_clk(ref_clk), .oeN(eOeN), .out(eOut), .pullEn(ePull),
    .extEn(8'hFF), .extVal(eExt), .pin(eIn));
  pad_bank i_padF (.ref_clk(ref_clk), .oeN(fOeN), .out(fOut), .pullEn(fPull),
    .extEn(fExtEn), .extVal(fExt), .pin(fIn));

  // ==========
  // Helpers
  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      wrap_up();
    end
  end

  function automatic logic [7:0] rnd();
    repeat (8) lfsr = {lfsr[15:0], lfsr[16] ^ lfsr[13]};
    return lfsr[7:0];
  endfunction

  // Expected enables, bits 5 4 2 1 0; m bits 3:0 hold rx, tx, txd, twoWire, bits 7:6 the holds
  function automatic logic [4:0] expOe(input logic [7:0] l, d, mm);
    logic [1:0] tw;
    tw = mm[0] ? ~({mm[6] | l[5], mm[7] | l[4]} & d[5:4]) : ~d[5:4];
    return {tw, ~d[2], ~d[1] & ~mm[2], ~d[0] | mm[3]};
  endfunction

  task automatic check(input logic [31:0] seen, exp, input string msg);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic w(input int k);
    repeat (k) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  // Ready and read data are taken at the rising edge at which the slave sees ready high
  task automatic apb(input logic isWr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rdat, output logic err);
    int t;
    t = 0;
    @(posedge ref_clk);
    psel <= 1'b1; pwrite <= isWr; paddr <= a; pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    if (pready !== 1'b1) n_errors++;
    rdat = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r; logic x;
    apb(1'b1, a, d, r, x);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic x;
    apb(1'b0, a, '0, r, x);
  endtask

  // One test clock period, each phase well over three system clocks
  task automatic step(input logic tms, tdi, oe);
    @(posedge ref_clk); fExt <= {tdi, 1'b0, tms, 5'h00}; w(4);
    @(posedge ref_clk); fExt[4] <= 1'b1; w(4);
    @(posedge ref_clk); fExt[4] <= 1'b0; w(4);
    check(fOeN[6], oe, "data-out drive");
  endtask

  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ==========
  // Scenarios
  initial begin
    repeat (4) @(posedge ref_clk);
    srst <= 1'b0;
    lat = rnd();
    wr(`PAO_OFS_PORTE_DIR, {24'h0, lat}); rd(`PAO_OFS_PORTE_DIR, q);
    check(q, {24'h0, lat}, "direction readback");
    apb(1'b0, 8'h30, '0, q, e);
    check(q, '0, "unmapped read data");
    check(e, 1'b1, "unmapped read error");
    for (int k = 0; k < 24; k++) begin
      lat = rnd(); dir = rnd(); m = rnd();
      wr(`PAO_OFS_PORTE_LATCH, {24'h0, lat}); wr(`PAO_OFS_PORTE_DIR, {24'h0, dir});
      @(posedge ref_clk);
      {syncClk, syncMode, receiver_enable, transmitter_enable, txd, twoWire} <= m[5:0];
      {clkHold, dataHold} <= m[7:6];
      threeWire <= lat[7] ^ dir[7];
      eExt <= rnd();
      w(3);
      check({eOeN[5:4], eOeN[2:0]}, expOe(lat, dir, m), "pin direction");
      if (m[3]) check(ePull[0], lat[0], "receive pull-up");
      if (m[2]) check({ePull[1], eOut[1]}, {1'b0, m[1]}, "transmit pin");
      if (m[0]) check({ePull[5:4], eOut[5:4] & ~eOeN[5:4]}, '0, "two-wire pins");
      if (dir[2]) check(eOut[2], m[4] ? m[5] : lat[2], "clock pin value");
      check(eOut[6], (lat[7] ^ dir[7]) ? m[1] : lat[6], "serial data out");
    end
    @(posedge ref_clk); {syncMode, receiver_enable, transmitter_enable, twoWire} <= '0; eExt <= '0;
    wr(`PAO_OFS_PORTE_DIR, '0); wr(`PAO_OFS_CHANGE_MASK, 32'h1); wr(`PAO_OFS_CTRL, 32'h1);
    wr(`PAO_OFS_IRQ_STATUS, 32'h1FF); wr(`PAO_OFS_IRQ_MASK, 32'h1);
    @(posedge ref_clk); eExt <= 8'h01; w(8);
    check(eDig, 8'h01, "input enable");
    check(irq, 1'b1, "interrupt raised");
    rd(`PAO_OFS_IRQ_STATUS, q); check(q[8:0], 9'h001, "change status");
    wr(`PAO_OFS_IRQ_MASK, '0); w(2); check(irq, 1'b0, "interrupt masked");
    wr(`PAO_OFS_IRQ_STATUS, 32'h1); rd(`PAO_OFS_IRQ_STATUS, q); check(q[8:0], '0, "status cleared");
    wr(`PAO_OFS_CTRL, '0); w(3); check(eDig, '0, "group disabled");
    @(posedge ref_clk); fuse <= 1'b1; w(3);
    check(eOeN[7], 1'b0, "clock pin driven");
    n = 0;
    repeat (8 * DIV) begin
      lat[7] = eOut[7]; w(1);
      if (eOut[7] !== lat[7]) n++;
    end
    check(n, 8, "clock toggles");
    @(posedge ref_clk); fuse <= 1'b0;
    lat = rnd();
    wr(`PAO_OFS_PORTF_DIR, 32'hF); wr(`PAO_OFS_PORTF_LATCH, {24'h0, lat}); w(3);
    check({fOeN[3:0], fOut[3:0]}, {4'h0, lat[3:0]}, "analog pins plain");
    rd(`PAO_OFS_PORTF_PIN, q); check(q[3:0], lat[3:0], "analog pins read");
    // Port F registers are left untouched while the scan traffic runs
    @(posedge ref_clk); fExtEn <= 8'hB0; fExt <= 8'hA0; scanEn <= 1'b1; w(3);
    check(fPull[7:4], 4'hF, "scan pull-ups");
    rd(`PAO_OFS_PORTF_PIN, q); check(q[7:4], '0, "scan pins hidden");
    lat = rnd();
    repeat (5) step(1, 0, 1);
    step(0, 0, 1); step(1, 0, 1); step(1, 0, 1); step(0, 0, 1); step(0, 0, 0);
    check(fOut[6], 1'b1, "capture bit out");
    for (int i = 0; i < 4; i++) step(i == 3, i == 1, i == 3);
    step(1, 0, 1); step(1, 0, 1); step(0, 0, 1); step(0, 0, 0);
    for (int i = 0; i < 7; i++) step(0, lat[i], 0);
    @(posedge ref_clk); fExt[5] <= 1'b1; w(10);
    check(fOeN[6], 1'b0, "state held without test clock");
    step(1, lat[7], 1); step(1, 0, 1); step(0, 0, 1);
    rd(`PAO_OFS_SCAN_DATA, q); check(q[7:0], lat, "scan register");
    rd(`PAO_OFS_IRQ_STATUS, q); check(q[8], 1'b1, "scan update event");
    @(posedge ref_clk); rstPin <= 1'b0; w(4);
    check(rstPull, 1'b1, "reset pin pull-up");
    rd(`PAO_OFS_MISC_STATUS, q); check(q[1:0], 2'h2, "reset pin input");
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
